/* File: lmd_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lmd_map.svh"

module lmd_sequencer #(
  parameter int SLOT_CYCLES = `LMD_SLOT_TIME_US * `LMD_CLK_MHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // lcd drive level selections
  output logic [1:0] backplane_out_first,
  output logic [1:0] backplane_out_second,
  output logic [1:0] backplane_out_third,
  output logic [1:0] backplane_out_fourth,
  output logic [159:0] segment_outputs,
  output logic [1:0] lcd_supply_level
);

  // ************************************************************
  // helper functions
  // ************************************************************
  function automatic logic [2:0] slot_count(input lmd_pkg::lmd_mode_e m);
    slot_count = 3'({1'b0, m} + 3'h1);
  endfunction

  function automatic logic [1:0] bp_slot(input lmd_pkg::lmd_mode_e m, input logic [1:0] i);
    unique case (m)
      lmd_pkg::MODE_STATIC: bp_slot = 2'h0;
      lmd_pkg::MODE_MUX2: bp_slot = {1'b0, i[0]};
      lmd_pkg::MODE_MUX3: bp_slot = (i == 2'h3) ? 2'h1 : i;
      lmd_pkg::MODE_MUX4: bp_slot = i;
    endcase
  endfunction

  function automatic logic [1:0] divisor(input lmd_pkg::lmd_mode_e m, input logic half);
    if (m == lmd_pkg::MODE_STATIC) begin
      divisor = 2'h1;
    end else begin
      divisor = half ? 2'h2 : 2'h3;
    end
  endfunction

  function automatic lmd_pkg::lmd_level_t bp_lvl(input logic sel, input logic h, input logic [1:0] d);
    if (sel) begin
      bp_lvl = h ? 2'h0 : d;
    end else begin
      bp_lvl = h ? 2'(d - 2'h1) : 2'h1;
    end
  endfunction

  function automatic lmd_pkg::lmd_level_t seg_lvl(input logic on, input logic h, input logic [1:0] d);
    if (on) begin
      seg_lvl = h ? d : 2'h0;
    end else if (d == 2'h1) begin
      seg_lvl = h ? 2'h0 : 2'h1;
    end else begin
      seg_lvl = h ? 2'h1 : 2'(d - 2'h1);
    end
  endfunction

  function automatic logic ram_hit(input logic [11:0] a);
    ram_hit = a >= `LMD_OFF_RAM_BASE && a < 12'(`LMD_OFF_RAM_BASE + 4 * `LMD_RAM_WORDS);
  endfunction

  // ************************************************************
  // register bus
  // ************************************************************
  logic [31:0] ctrl_r;
  logic [31:0] ram_r [0:`LMD_RAM_WORDS-1];
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] status;
  logic [31:0] rd_val;
  logic [3:0] rd_idx;
  logic [3:0] wr_idx;
  logic acc;

  assign acc = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign rd_idx = 4'(haddr[11:2] - 10'(`LMD_OFF_RAM_BASE >> 2));
  assign wr_idx = 4'(wr_addr_r[11:2] - 10'(`LMD_OFF_RAM_BASE >> 2));

  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr[11:2] == 10'(`LMD_OFF_CTRL >> 2)) begin
      rd_val = ctrl_r;
    end else if (haddr[11:2] == 10'(`LMD_OFF_STATUS >> 2)) begin
      rd_val = status;
    end else if (ram_hit(haddr)) begin
      rd_val = ram_r[rd_idx];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= acc && hwrite;
      if (acc) begin
        wr_addr_r <= haddr;
      end
      if (acc && !hwrite) begin
        hrdata_r <= rd_val;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r <= `LMD_CTRL_RESET;
    end else if (wr_pend_r && wr_addr_r[11:2] == 10'(`LMD_OFF_CTRL >> 2)) begin
      ctrl_r <= {27'h0000000, hwdata[4:0]};
    end
  end

  genvar gw;
  generate
    for (gw = 0; gw < `LMD_RAM_WORDS; gw++) begin : g_ram
      always_ff @(posedge clk) begin
        if (!rstn) begin
          ram_r[gw] <= 32'h0000_0000;
        end else if (wr_pend_r && ram_hit(wr_addr_r) && wr_idx == 4'(gw)) begin
          ram_r[gw] <= hwdata;
        end
      end
    end
  endgenerate

  // ************************************************************
  // frame sequencing
  // ************************************************************
  lmd_pkg::lmd_state_e state_r;
  lmd_pkg::lmd_mode_e mode_r;
  logic half_bias_r;
  logic bank_r;
  logic [15:0] cnt_r;
  logic [1:0] slot_r;
  logic phase_r;
  logic [79:0] disp_r;
  logic slot_end;
  logic last_slot;
  logic frame_end;
  logic [1:0] slot_nxt;
  logic [1:0] row_nxt;
  logic [1:0] div_r;
  logic ctrl_en;
  logic [3:0] row_base;

  assign ctrl_en = ctrl_r[`LMD_CTRL_EN_BIT];
  assign row_base = 4'(3 * row_nxt);
  assign slot_end = cnt_r == 16'(SLOT_CYCLES - 1);
  assign last_slot = {1'b0, slot_r} == 3'(slot_count(mode_r) - 3'h1);
  assign frame_end = slot_end && last_slot && phase_r;
  assign slot_nxt = (state_r == lmd_pkg::ST_BLANK || (slot_end && last_slot)) ? 2'h0 :
                    (slot_end ? 2'(slot_r + 2'h1) : slot_r);
  // bank switch only applies in static and 1:2
  assign row_nxt = (bank_r && (mode_r == lmd_pkg::MODE_STATIC || mode_r == lmd_pkg::MODE_MUX2)) ?
                   2'(slot_nxt + 2'h2) : slot_nxt;
  assign status = {23'h000000, div_r, phase_r, slot_r, mode_r, half_bias_r, state_r == lmd_pkg::ST_DRIVE};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= lmd_pkg::ST_BLANK;
    end else begin
      unique case (state_r)
        lmd_pkg::ST_BLANK: if (ctrl_en) state_r <= lmd_pkg::ST_DRIVE;
        lmd_pkg::ST_DRIVE: if (!ctrl_en) state_r <= lmd_pkg::ST_BLANK;
        default: state_r <= lmd_pkg::ST_BLANK;
      endcase
    end
  end

  // configuration is taken only between frames so each frame is balanced
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_r <= lmd_pkg::MODE_STATIC;
      half_bias_r <= 1'b0;
      bank_r <= 1'b0;
    end else if (state_r == lmd_pkg::ST_BLANK || frame_end) begin
      mode_r <= lmd_pkg::lmd_mode_e'(ctrl_r[`LMD_CTRL_MODE_LSB +: 2]);
      half_bias_r <= ctrl_r[`LMD_CTRL_HALF_BIT];
      bank_r <= ctrl_r[`LMD_CTRL_BANK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= 16'h0000;
      slot_r <= 2'h0;
      phase_r <= 1'b0;
    end else if (state_r == lmd_pkg::ST_BLANK) begin
      cnt_r <= 16'h0000;
      slot_r <= 2'h0;
      phase_r <= 1'b0;
    end else begin
      cnt_r <= slot_end ? 16'h0000 : 16'(cnt_r + 16'h0001);
      slot_r <= slot_nxt;
      if (slot_end && last_slot) begin
        phase_r <= !phase_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      disp_r <= 80'h0;
    end else begin
      disp_r <= {ram_r[4'(row_base + 4'h2)][15:0], ram_r[4'(row_base + 4'h1)], ram_r[row_base]};
    end
  end

  // ************************************************************
  // level selection outputs
  // ************************************************************
  lmd_pkg::lmd_level_t bp_r [0:3];
  logic drive;

  assign drive = state_r == lmd_pkg::ST_DRIVE;
  assign backplane_out_first = bp_r[0];
  assign backplane_out_second = bp_r[1];
  assign backplane_out_third = bp_r[2];
  assign backplane_out_fourth = bp_r[3];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_r <= 2'h1;
    end else begin
      div_r <= divisor(mode_r, half_bias_r);
    end
  end
  assign lcd_supply_level = div_r;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_bp
      always_ff @(posedge clk) begin
        if (!rstn || !drive) begin
          bp_r[gb] <= 2'h0;
        end else begin
          bp_r[gb] <= bp_lvl(bp_slot(mode_r, 2'(gb)) == slot_r, phase_r, divisor(mode_r, half_bias_r));
        end
      end
    end
    for (gb = 0; gb < 80; gb++) begin : g_seg
      always_ff @(posedge clk) begin
        if (!rstn || !drive) begin
          segment_outputs[2*gb +: 2] <= 2'h0;
        end else begin
          segment_outputs[2*gb +: 2] <= seg_lvl(disp_r[gb], phase_r, divisor(mode_r, half_bias_r));
        end
      end
    end
  endgenerate

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_blank_common: assert property (!drive |=> bp_r[0] == 2'h0 && segment_outputs == 160'h0)
    else $error("blank outputs not at common level");
  chk_enable_gate: assert property (!ctrl_en |=> !drive)
    else $error("drive while enable clear");
  chk_static_same: assert property (drive && mode_r == lmd_pkg::MODE_STATIC |=>
    bp_r[0] == bp_r[1] && bp_r[1] == bp_r[2] && bp_r[2] == bp_r[3])
    else $error("static backplanes differ");
  chk_mux2_pairs: assert property (drive && mode_r == lmd_pkg::MODE_MUX2 |=>
    bp_r[0] == bp_r[2] && bp_r[1] == bp_r[3])
    else $error("1:2 backplane pairs differ");
  chk_mux3_copy: assert property (drive && mode_r == lmd_pkg::MODE_MUX3 |=> bp_r[3] == bp_r[1])
    else $error("1:3 fourth backplane differs");
  chk_slot_range: assert property ({1'b0, slot_r} < slot_count(mode_r))
    else $error("slot beyond mode count");
  chk_phase_flip: assert property ($changed(phase_r) && drive && $past(drive) |-> $past(slot_end && last_slot))
    else $error("polarity changed mid frame half");
  chk_config_hold: assert property ($changed(mode_r) |-> $past(!drive || frame_end))
    else $error("mode changed inside frame");
  chk_level_range: assert property (drive |=> bp_r[0] <= div_r && segment_outputs[1:0] <= div_r)
    else $error("level above supply");

  cov_mux4_frame: cover property (drive && mode_r == lmd_pkg::MODE_MUX4 && frame_end);
  cov_mux3_half: cover property (drive && mode_r == lmd_pkg::MODE_MUX3 && half_bias_r && frame_end);
  cov_bank_static: cover property (drive && mode_r == lmd_pkg::MODE_STATIC && bank_r && slot_end);
  cov_blank_again: cover property (drive ##1 !drive);

endmodule // lmd_sequencer

`default_nettype wire

/* File: lmd_map.svh */
`ifndef LMD_MAP_SVH
`define LMD_MAP_SVH

// ************************************************************
// register byte offsets and display ram size
// ************************************************************
`define LMD_OFF_CTRL 12'h000
`define LMD_OFF_STATUS 12'h004
`define LMD_OFF_RAM_BASE 12'h040
`define LMD_RAM_WORDS 12
`define LMD_WORDS_PER_ROW 3

// ************************************************************
// control field positions and reset value
// ************************************************************
`define LMD_CTRL_MODE_LSB 0
`define LMD_CTRL_HALF_BIT 2
`define LMD_CTRL_EN_BIT 3
`define LMD_CTRL_BANK_BIT 4
`define LMD_CTRL_RESET 32'h0000_0000

// ************************************************************
// timing: backplane slot length
// ************************************************************
`define LMD_CLK_MHZ 10
`define LMD_SLOT_TIME_US 1000

`endif

/* File: lmd_pkg.sv */
`default_nettype none
package lmd_pkg;
  typedef enum logic [1:0] {
    MODE_STATIC = 2'h0,
    MODE_MUX2 = 2'h1,
    MODE_MUX3 = 2'h2,
    MODE_MUX4 = 2'h3
  } lmd_mode_e;

  typedef enum logic [1:0] {
    ST_BLANK = 2'b01,
    ST_DRIVE = 2'b10
  } lmd_state_e;

  // drive level as a number of bias steps above ground
  typedef logic [1:0] lmd_level_t;
endpackage

`default_nettype wire

/* File: lmd_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// panel cell: running dc charge across the first segment
// ************************************************************
module lmd_panel_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // electrode levels of one cell
  input wire logic [1:0] bp_level,
  input wire logic [1:0] seg_level,
  // accumulated segment minus backplane level
  output logic signed [15:0] dc_acc
);
  always @(posedge clk) begin
    if (!rstn) begin
      dc_acc <= '0;
    end else begin
      dc_acc <= dc_acc + $signed({14'h0, seg_level}) - $signed({14'h0, bp_level});
    end
  end
endmodule // lmd_panel_model

`default_nettype wire

/* File: lmd_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end

module lmd_sequencer_tb;
  localparam int SLOT = 4;
  logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0, bp0, bp1, bp2, bp3, sup;
  logic [31:0] hwdata = '0, hrdata, rnd = 32'hc2398c2c, tmp, ramv [12];
  logic [159:0] seg;
  logic signed [15:0] dc_acc, snap;
  logic [33:0] exp_q [$], ex;
  logic [17:0] obs;
  int fail_count = 0, n_tests = 0, cyc = 0, m, n, hb, found;

  always #50 clk = ~clk;
  assign obs = {sup, seg[159:158], seg[81:80], seg[3:2], seg[1:0], bp3, bp2, bp1, bp0};

  lmd_sequencer #(.SLOT_CYCLES(SLOT)) lmd_sequencer_i (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .backplane_out_first(bp0), .backplane_out_second(bp1),
    .backplane_out_third(bp2), .backplane_out_fourth(bp3), .segment_outputs(seg), .lcd_supply_level(sup));

  lmd_panel_model lmd_panel_model_i (.clk(clk), .rstn(rstn), .bp_level(bp0), .seg_level(seg[1:0]),
    .dc_acc(dc_acc));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  // expected {divisor, seg79, seg40, seg1, seg0, bp3..bp0} in phase p, slot s
  function automatic logic [17:0] lv(input int m, input int hb, input int p, input int s);
    int d;
    int r;
    int ks [4] = '{0, 1, 40, 79};
    logic [17:0] v;
    logic [1:0] on;
    logic [1:0] off;
    logic sel;
    d = (m == 0) ? 1 : 3 - hb;
    r = (hb == 1 && m < 2) ? s + 2 : s;
    on = 2'(p ? d : 0);
    off = 2'((m == 0) ? 1 - p : (p ? 1 : d - 1));
    v[17:16] = 2'(d);
    for (int i = 0; i < 4; i++) begin
      sel = (m == 0) || (m == 1 && i % 2 == s) || (m == 2 && (i == 3 ? s == 1 : i == s)) || (m == 3 && i == s);
      v[2*i+:2] = sel ? 2'(p ? 0 : d) : 2'(p ? d - 1 : 1);
    end
    for (int j = 0; j < 4; j++) begin
      v[8+2*j+:2] = ramv[3*r + ks[j]/32][ks[j]%32] ? on : off;
    end
    return v;
  endfunction

  task automatic note(input logic [1:0] k, input logic [31:0] v);
    #1;
    exp_q.push_back({k, v});
  endtask

  // one single transfer; for a read d is the expected data
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) note(2'h0, d);
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ************************************************************
  // watcher and timeout
  // ************************************************************
  always @(posedge clk) begin
    if (exp_q.size() > 0) begin
      ex = exp_q.pop_front();
      case (ex[33:32])
        2'h0: begin
          `CHK("hrdata", ex[31:0], hrdata)
          `CHK("hresp", 1'b0, hresp)
        end
        2'h1: `CHK("drive levels", ex[17:0], obs)
        2'h2: `CHK("blank levels", ex[15:0], obs[15:0])
        default: `CHK("panel dc", ex[15:0], dc_acc - snap)
      endcase
    end
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      finish_test();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    ahb(1'b0, 12'h000, 32'h0);
    ahb(1'b0, 12'h100, 32'h0);
    ahb(1'b1, 12'h000, 32'h3);
    repeat (4 * SLOT) @(posedge clk);
    note(2'h2, 32'h0);
    for (int c = 0; c < 8; c++) begin
      m = c % 4;
      hb = c / 4;
      n = m + 1;
      for (int w = 0; w < 12; w++) begin
        ramv[w] = xs();
        ahb(1'b1, 12'(64 + 4 * w), ramv[w]);
      end
      ahb(1'b0, 12'h04c, ramv[3]);
      ahb(1'b0, 12'h100, 32'h0);
      tmp = xs();
      ahb(1'b1, 12'h000, {tmp[31:5], 5'(8 + 20 * hb + m)});
      ahb(1'b0, 12'h000, 32'(8 + 20 * hb + m));
      found = 0;
      for (int t = 0; t < 40 && !found; t++) begin
        @(posedge clk);
        #1;
        found = int'(bp0 === 2'(m == 0 ? 1 : 3 - hb));
      end
      `CHK("frame start", 1'b1, 1'(found))
      snap = dc_acc;
      for (int j = 0; j < 2 * n; j++) begin
        @(posedge clk);
        note(2'h1, 32'(lv(m, hb, j / n, j % n)));
        repeat (SLOT - 1) @(posedge clk);
      end
      note(2'h3, 32'h0);
      ahb(1'b1, 12'h000, 32'(m));
      repeat (3) @(posedge clk);
      note(2'h2, 32'h0);
      ahb(1'b0, 12'h004, 32'((m == 0 ? 1 : 3) * 128 + 4 * m));
    end
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule // lmd_sequencer_tb

`default_nettype wire
